// ==== logic/spi_clock_format_control.sv ====
// How it works
// - idle-level select 0 parks the clock high, 1 parks it low.
// - idle high, capture-edge select 0: sample data on rising clock edge.
// - idle high, capture-edge select 1: sample data on falling clock edge.
// - idle low, capture-edge select 0: sample data on falling clock edge.
// - master modes make the clock here; slave mode 101 takes the external clock.
// - interface off floats data, clock and select lines and halts activity.
`timescale 1ns/100ps
`default_nettype none
module spi_clock_format_control
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_sck,
	output logic             o_sck,
	output logic             o_sck_oe,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	output logic             o_sdo_oe,
	input  wire logic        i_scs_n,
	output logic             o_scs_n,
	output logic             o_scs_n_oe
);

	// software-visible state
	logic [2:0]               mode_ff;
	logic                     on_ff;
	logic [7:0]               data_ff;
	spi_fmt_pkg::fmt_reg_t    fmt_ff;
	logic                     wcol_en_ff;

	// bus answer state
	logic                     ack_ff;
	logic [31:0]              rdata_ff;

	// pin synchronisers
	logic                     sck_s1_ff;
	logic                     sck_s2_ff;
	logic                     sck_s3_ff;
	logic                     sdi_s1_ff;
	logic                     sdi_s2_ff;
	logic                     scs_s1_ff;
	logic                     scs_s2_ff;

	// shifter state
	logic                     busy_ff;
	logic                     sck_ff;
	logic [5:0]               div_ff;
	logic [4:0]               edge_cnt_ff;
	logic [2:0]               cap_cnt_ff;
	logic [7:0]               tx_ff;
	logic [7:0]               rx_ff;

	// bus decode
	wire       req        = i_avs_read | i_avs_write;
	wire       wr_low     = i_avs_write & ack_ff & i_avs_byteenable[0];
	wire       wr_mode    = wr_low & (i_avs_address == spi_fmt_pkg::OFS_MODE);
	wire       wr_data    = wr_low & (i_avs_address == spi_fmt_pkg::OFS_DATA);
	wire       wr_fmt     = wr_low & (i_avs_address == spi_fmt_pkg::OFS_FMT);
	wire       wr_wctl    = wr_low & (i_avs_address == spi_fmt_pkg::OFS_WCTL);
	wire [7:0] wbyte      = i_avs_writedata[7:0];

	// mode decode
	wire       is_slave   = (mode_ff == spi_fmt_pkg::MODE_SLAVE);
	wire       is_master  = (mode_ff <= spi_fmt_pkg::MODE_M_ALT1);
	// modes 110 and 111 count as off: no shifting and every pin floating
	wire       spi_on     = on_ff & (is_master | is_slave);
	wire       idle_lvl   = ~fmt_ff.idle_level_select;
	// one xor covers all four polarity/edge pairings: equal bits mean a rising
	// capture edge, different bits a falling one
	wire       cap_rise   = ~(fmt_ff.idle_level_select ^ fmt_ff.capture_edge_select);

	// master clock divider selection; the two alternate sources are not present
	// here, so both run at the slowest rate
	// limitation: at the fastest rate a half period is only two clocks, as long as
	// the input synchroniser, so data that the far side changes on the launch edge
	// arrives too late; the slower rates leave ample margin
	logic [5:0] half_cnt;
	always_comb
	begin
		case (mode_ff)
			spi_fmt_pkg::MODE_M_DIV4:  half_cnt = spi_fmt_pkg::HALF_DIV4;
			spi_fmt_pkg::MODE_M_DIV16: half_cnt = spi_fmt_pkg::HALF_DIV16;
			spi_fmt_pkg::MODE_M_DIV64: half_cnt = spi_fmt_pkg::HALF_DIV64;
			default:                   half_cnt = spi_fmt_pkg::HALF_ALT;
		endcase
	end

	// edges of the serial clock, own in master modes, synchronised in slave
	wire       m_tick     = spi_on & is_master & busy_ff & (div_ff == 6'h00);
	wire       m_rise     = m_tick & ~sck_ff;
	wire       m_fall     = m_tick & sck_ff;
	// the select pin only counts once software has switched it on
	wire       s_sel      = ~fmt_ff.select_pin_on | ~scs_s2_ff;
	wire       s_act      = spi_on & is_slave & s_sel;
	wire       s_rise     = s_act & sck_s2_ff & ~sck_s3_ff;
	wire       s_fall     = s_act & ~sck_s2_ff & sck_s3_ff;
	wire       any_rise   = is_master ? m_rise : s_rise;
	wire       any_fall   = is_master ? m_fall : s_fall;
	wire       cap_edge   = cap_rise ? any_rise : any_fall;
	wire       lau_edge   = cap_rise ? any_fall : any_rise;

	// a launch before the first capture would drop the first bit; the frame ends
	// on the sixteenth master edge, or on the eighth capture in slave mode
	wire       do_shift   = lau_edge & (cap_cnt_ff != 3'h0);
	wire       m_done     = m_tick & (edge_cnt_ff == spi_fmt_pkg::LAST_EDGE);
	wire       s_done     = is_slave & cap_edge & (cap_cnt_ff == spi_fmt_pkg::LAST_CAP);
	wire       done       = m_done | s_done;

	// received byte including the bit captured this cycle
	wire [7:0] rx_next    = fmt_ff.msb_first ? {rx_ff[6:0], sdi_s2_ff}
	                                         : {sdi_s2_ff, rx_ff[7:1]};
	wire [7:0] tx_shift   = fmt_ff.msb_first ? {tx_ff[6:0], 1'b0} : {1'b0, tx_ff[7:1]};
	wire       rx_final   = cap_edge ? 1'b1 : 1'b0;
	wire [7:0] done_byte  = rx_final ? rx_next : rx_ff;

	// data writes start a master frame or collide with a running one; a colliding
	// write is dropped whether or not the collision flag is enabled
	wire       load_ok    = wr_data & ~busy_ff;
	wire       m_start    = load_ok & spi_on & is_master;
	wire       collide    = wr_data & busy_ff & wcol_en_ff;

	// read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		case (i_avs_address)
			spi_fmt_pkg::OFS_MODE: rd_mux = {24'h000000, mode_ff, 3'h0, on_ff, 1'b0};
			spi_fmt_pkg::OFS_DATA: rd_mux = {24'h000000, data_ff};
			spi_fmt_pkg::OFS_FMT:  rd_mux = {24'h000000, fmt_ff};
			spi_fmt_pkg::OFS_WCTL: rd_mux = {24'h000000, wcol_en_ff, 7'h00};
			default:               rd_mux = 32'h00000000;
		endcase
	end

	// bus answer: one wait cycle, then the request completes; read data is taken
	// from the first request cycle so it stands while waitrequest is low
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff   <= req & ~ack_ff;
			rdata_ff <= rd_mux;
		end
	end

	assign o_avs_waitrequest = req & ~ack_ff;
	assign o_avs_readdata    = rdata_ff;

	// pin synchronisers, third sck stage only for edge detection; select resets
	// high so a slave is not selected straight out of reset
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_s3_ff <= 1'b0;
			sdi_s1_ff <= 1'b0;
			sdi_s2_ff <= 1'b0;
			scs_s1_ff <= 1'b1;
			scs_s2_ff <= 1'b1;
		end
		else
		begin
			sck_s1_ff <= i_sck;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			sdi_s1_ff <= i_sdi;
			sdi_s2_ff <= sdi_s1_ff;
			scs_s1_ff <= i_scs_n;
			scs_s2_ff <= scs_s1_ff;
		end
	end

	// mode and collision-control registers; format bits are not guarded here, so
	// software must set them before switching on
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			mode_ff    <= spi_fmt_pkg::MODE_RST;
			on_ff      <= 1'b0;
			wcol_en_ff <= 1'b0;
		end
		else
		begin
			if (wr_mode)
			begin
				mode_ff <= wbyte[spi_fmt_pkg::MODE_LSB +: 3];
				on_ff   <= wbyte[spi_fmt_pkg::ON_BIT];
			end
			if (wr_wctl)
				wcol_en_ff <= wbyte[spi_fmt_pkg::WCOL_EN_BIT];
		end
	end

	// clock format register; hardware set of the flags wins over a clear so an
	// event in the cycle of a clearing write is never lost; spare bits steer nothing
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			fmt_ff <= spi_fmt_pkg::fmt_reg_t'(spi_fmt_pkg::FMT_RST);
		else
		begin
			if (wr_fmt)
				fmt_ff <= spi_fmt_pkg::fmt_reg_t'(wbyte);
			if (collide)
				fmt_ff.write_collision <= 1'b1;
			if (done)
				fmt_ff.transfer_done <= 1'b1;
		end
	end

	// data register: software write when idle, received byte at frame end;
	// a frame end needs busy, so it never meets an accepted write
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			data_ff <= 8'h00;
		else if (done)
			data_ff <= done_byte;
		else if (load_ok)
			data_ff <= wbyte;
	end

	// shifter and master clock; switching off stops it at once
	always_ff @(posedge i_clk)
	begin
		if (i_srst | ~spi_on)
		begin
			busy_ff     <= 1'b0;
			sck_ff      <= idle_lvl;
			div_ff      <= 6'h00;
			edge_cnt_ff <= 5'h00;
			cap_cnt_ff  <= 3'h0;
			tx_ff       <= 8'h00;
			rx_ff       <= 8'h00;
		end
		// a slave deselected mid-frame drops the partial byte and sets no flag
		else if (is_slave & ~s_sel)
		begin
			busy_ff    <= 1'b0;
			cap_cnt_ff <= 3'h0;
		end
		else
		begin
			if (load_ok)
				tx_ff <= wbyte;
			else if (do_shift)
				tx_ff <= tx_shift;
			if (cap_edge)
			begin
				rx_ff      <= rx_next;
				cap_cnt_ff <= cap_cnt_ff + 3'h1;
			end
			if (done)
				busy_ff <= 1'b0;
			else if (m_start | (is_slave & cap_edge))
				busy_ff <= 1'b1;
			// master clock runs only while a frame is active
			if (~busy_ff | m_done)
			begin
				sck_ff      <= idle_lvl;
				div_ff      <= half_cnt;
				edge_cnt_ff <= 5'h00;
			end
			else if (is_master)
			begin
				if (m_tick)
				begin
					sck_ff      <= ~sck_ff;
					div_ff      <= half_cnt;
					edge_cnt_ff <= edge_cnt_ff + 5'h01;
				end
				else
					div_ff <= div_ff - 6'h01;
			end
		end
	end

	// pins float whenever the interface is off; left to software, since a
	// format change while on moves the idle level of the clock at once
	assign o_sck      = sck_ff;
	assign o_sck_oe   = spi_on & is_master;
	assign o_sdo      = fmt_ff.msb_first ? tx_ff[7] : tx_ff[0];
	assign o_sdo_oe   = spi_on & (is_master | s_sel);
	assign o_scs_n    = ~busy_ff;
	assign o_scs_n_oe = spi_on & is_master & fmt_ff.select_pin_on;

endmodule
`default_nettype wire

// ==== logic/spi_fmt_pkg.sv ====
`default_nettype none
package spi_fmt_pkg;

	// register byte offsets
	localparam logic [3:0] OFS_MODE  = 4'h0;
	localparam logic [3:0] OFS_DATA  = 4'h4;
	localparam logic [3:0] OFS_FMT   = 4'h8;
	localparam logic [3:0] OFS_WCTL  = 4'hC;

	// field positions
	localparam int MODE_LSB   = 5;
	localparam int ON_BIT     = 1;
	localparam int WCOL_EN_BIT = 7;

	// values after reset
	localparam logic [2:0] MODE_RST = 3'h7;
	localparam logic [7:0] FMT_RST  = 8'h00;

	// operating modes
	localparam logic [2:0] MODE_M_DIV4  = 3'h0;
	localparam logic [2:0] MODE_M_DIV16 = 3'h1;
	localparam logic [2:0] MODE_M_DIV64 = 3'h2;
	localparam logic [2:0] MODE_M_ALT0  = 3'h3;
	localparam logic [2:0] MODE_M_ALT1  = 3'h4;
	localparam logic [2:0] MODE_SLAVE   = 3'h5;

	// divider reload values of the master serial clock; a half period lasts the value plus one system clocks
	localparam logic [5:0] HALF_DIV4  = 6'h01;
	localparam logic [5:0] HALF_DIV16 = 6'h07;
	localparam logic [5:0] HALF_DIV64 = 6'h1F;
	localparam logic [5:0] HALF_ALT   = 6'h1F;

	// index of the last capture and of the last edge of a frame, counted from zero (8 bits, 16 edges)
	localparam logic [2:0] LAST_CAP  = 3'h7;
	localparam logic [4:0] LAST_EDGE = 5'h0F;

	// clock format register layout
	typedef struct packed {
		logic [1:0] spare_bits;
		logic       idle_level_select;
		logic       capture_edge_select;
		logic       msb_first;
		logic       select_pin_on;
		logic       write_collision;
		logic       transfer_done;
	} fmt_reg_t;

endpackage
`default_nettype wire

// ==== test/spi_clock_format_control_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_clock_format_control_tb_top;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        ext_sck = 1'b1;
	logic        ext_run = 1'b0;
	logic        ext_cs_n = 1'b1;
	logic [7:0]  far_rx;
	logic        start = 1'b1;
	logic        cap_rise = 1'b1;
	logic [7:0]  tx = 8'h00;
	logic [15:0] lfsr = 16'h229B;
	logic [31:0] rdata, q;
	logic        waitreq, sck, sck_oe, sdi, sdo, sdo_oe, scs_n, scs_n_oe;
	int          failures = 0;
	int          num_checks = 0;
	always #12.5 clk = ~clk;
	// slave-side link clock only toggles while a frame is wanted
	always #100 if (ext_run) ext_sck = ~ext_sck;
	spi_clock_format_control u_spi_clock_format_control (.i_clk(clk), .i_srst(srst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_sck(ext_sck), .o_sck(sck), .o_sck_oe(sck_oe), .i_sdi(sdi), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .i_scs_n(ext_cs_n), .o_scs_n(scs_n), .o_scs_n_oe(scs_n_oe));
	spi_far_slave u_spi_far_slave (.i_clk(clk), .i_sck(sck), .i_sdo(sdo),
		.i_cap_rise(cap_rise), .i_start(start), .i_tx(tx), .o_sdi(sdi), .o_rx(far_rx));
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge, then released
	task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wr <= we;
		rd <= ~we;
		addr <= a;
		wdata <= {24'h0, d};
		do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 64);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 64)
		begin
			failures++;
			finish_test();
		end
	endtask
	initial
	begin
		#2000000;
		failures++;
		finish_test();
	end
	initial
	begin
		int k, n;
		logic [7:0] f, sent;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		start <= 1'b0;
		bus(1'b0, spi_fmt_pkg::OFS_FMT, 8'h00);
		check("format reset", {24'h0, spi_fmt_pkg::FMT_RST}, q);
		check("reset idle clock", 32'h1, {31'h0, sck});
		bus(1'b0, 4'h2, 8'h00);
		check("unmapped read", 32'h0, q);
		for (k = 0; k < 4; k++)
		begin
			f = {2'h0, k[1:0], 4'hC};
			cap_rise <= (k[1] == k[0]);
			bus(1'b1, spi_fmt_pkg::OFS_FMT, f);
			bus(1'b1, spi_fmt_pkg::OFS_MODE, 8'h22);
			bus(1'b0, spi_fmt_pkg::OFS_FMT, 8'h00);
			check("format", {24'h0, f}, q);
			check("idle clock", {31'h0, ~k[1]}, {31'h0, sck});
			lfsr = next_rand(lfsr);
			tx <= lfsr[7:0];
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			lfsr = next_rand(lfsr);
			sent = lfsr[7:0];
			bus(1'b1, spi_fmt_pkg::OFS_DATA, sent);
			@(negedge clk);
			check("select during frame", 32'h2, {30'h0, scs_n_oe, scs_n});
			n = 0;
			do begin bus(1'b0, spi_fmt_pkg::OFS_FMT, 8'h00); n++; end
				while (q[0] !== 1'b1 && n < 200);
			if (q[0] !== 1'b1)
			begin
				failures++;
				finish_test();
			end
			check("done flag", {24'h0, f | 8'h01}, q);
			bus(1'b0, spi_fmt_pkg::OFS_DATA, 8'h00);
			check("received byte", {24'h0, tx}, q);
			check("sent byte", {24'h0, sent}, {24'h0, far_rx});
			check("idle after frame", {31'h0, ~k[1]}, {31'h0, sck});
			bus(1'b1, spi_fmt_pkg::OFS_MODE, 8'h20);
			bus(1'b0, spi_fmt_pkg::OFS_FMT, 8'h00);
			check("pins off", 32'h0, {29'h0, sck_oe, sdo_oe, scs_n_oe});
			$display("format %0d finished", k);
		end
		bus(1'b1, spi_fmt_pkg::OFS_MODE, 8'hA2);
		ext_run = 1'b1;
		repeat (20) @(negedge clk);
		check("slave clock oe", 32'h0, {31'h0, sck_oe});
		check("deselected data oe", 32'h0, {31'h0, sdo_oe});
		@(posedge clk);
		ext_cs_n <= 1'b0;
		repeat (4) @(negedge clk);
		check("selected data oe", 32'h1, {31'h0, sdo_oe});
		check("selected clock oe", 32'h0, {31'h0, sck_oe});
		ext_run = 1'b0;
		$display("slave mode finished");
		finish_test();
	end
endmodule
bind spi_clock_format_control spi_clock_format_props u_spi_clock_format_props (.i_clk(i_clk),
	.i_srst(i_srst), .i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_waitrequest(o_avs_waitrequest), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
	.o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_scs_n_oe(o_scs_n_oe));
`default_nettype wire

// ==== test/spi_clock_format_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_clock_format_props
(
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire logic [3:0]  i_avs_address,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_sck,
	input wire logic        o_sck_oe,
	input wire logic        o_sdo,
	input wire logic        o_sdo_oe,
	input wire logic        o_scs_n_oe
);
	logic [7:0] mode_ff;
	logic [7:0] mode_q_ff;
	logic [1:0] fmt_ff;
	wire        take = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
	wire        sl_q = mode_q_ff[7:5] == spi_fmt_pkg::MODE_SLAVE;
	wire        ms_q = mode_q_ff[7:5] < spi_fmt_pkg::MODE_SLAVE;
	// shadow of what software wrote; oe changes at the same edge as mode_ff, mode_q_ff one clock later
	always_ff @(posedge i_clk)
	begin
		mode_q_ff <= i_srst ? 8'hE0 : mode_ff;
		if (i_srst)
			mode_ff <= 8'hE0;
		else if (take && i_avs_address == spi_fmt_pkg::OFS_MODE)
			mode_ff <= i_avs_writedata[7:0];
		if (i_srst)
			fmt_ff <= 2'h0;
		else if (take && i_avs_address == spi_fmt_pkg::OFS_FMT)
			fmt_ff <= i_avs_writedata[5:4];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	idle_park_a: assert property ($rose(o_sck_oe) |-> o_sck == ~fmt_ff[1])
		else $error("clock not at idle level when driven");
	off_float_a: assert property (!mode_ff[1] && !mode_q_ff[1] |-> !(o_sck_oe | o_sdo_oe | o_scs_n_oe))
		else $error("pins driven while interface off");
	slave_clk_a: assert property (mode_ff == mode_q_ff && mode_ff[1] && sl_q |-> !o_sck_oe)
		else $error("slave drives clock");
	master_clk_a: assert property (mode_ff == mode_q_ff && mode_ff[1] && ms_q |-> o_sck_oe)
		else $error("master clock not driven");
	cap_hi_rise_a: assert property (fmt_ff == 2'h0 && o_sck_oe && $rose(o_sck) |-> $stable(o_sdo))
		else $error("data moved on capture edge");
	cap_hi_fall_a: assert property (fmt_ff == 2'h1 && o_sck_oe && $fell(o_sck) |-> $stable(o_sdo))
		else $error("data moved on capture edge");
	cap_lo_fall_a: assert property (fmt_ff == 2'h2 && o_sck_oe && $fell(o_sck) |-> $stable(o_sdo))
		else $error("data moved on capture edge");
	cap_lo_rise_a: assert property (fmt_ff == 2'h3 && o_sck_oe && $rose(o_sck) |-> $stable(o_sdo))
		else $error("data moved on capture edge");
endmodule
`default_nettype wire

// ==== test/spi_far_slave.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_far_slave
(
	input  wire logic       i_clk,
	input  wire logic       i_sck,
	input  wire logic       i_sdo,
	input  wire logic       i_cap_rise,
	input  wire logic       i_start,
	input  wire logic [7:0] i_tx,
	output logic            o_sdi,
	output logic [7:0]      o_rx
);
	logic       sck_ff;
	logic [2:0] cnt_ff;
	wire        moved = i_sck != sck_ff;
	wire        cap   = moved && (i_sck == i_cap_rise);
	// data moves only on launch edges, so it is steady through each capture;
	// the design's own data is collected msb first on the same capture edges
	always_ff @(posedge i_clk)
	begin
		sck_ff <= i_sck;
		if (i_start)
		begin
			cnt_ff <= 3'h0;
			o_sdi  <= i_tx[7];
			o_rx   <= 8'h00;
		end
		else if (cap)
		begin
			cnt_ff <= cnt_ff + 3'h1;
			o_rx   <= {o_rx[6:0], i_sdo};
		end
		else if (moved)
			o_sdi <= i_tx[3'h7 - cnt_ff];
	end
endmodule
`default_nettype wire
